/* File: upf_map.svh */
// Register offsets, field positions, reset values and timing counts of the power factor stage
`ifndef UPF_MAP_SVH
`define UPF_MAP_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define UPF_CLK_HZ        20000000
`define UPF_TICK_MS       5
`define UPF_TICK_CYC      (`UPF_CLK_HZ / 1000 * `UPF_TICK_MS)
`define UPF_PRETRIG_MS    20
`define UPF_PREFAULT_MS   200
`define UPF_PRETRIG_TAP   (`UPF_PRETRIG_MS / `UPF_TICK_MS)
`define UPF_PREFAULT_TAP  (`UPF_PREFAULT_MS / `UPF_TICK_MS)
`define UPF_RESET_PCT     103
`define UPF_PCT           100

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define UPF_CTRL          8'h00
`define UPF_TRIP_SET      8'h04
`define UPF_ALARM_SET     8'h08
`define UPF_TRIP_DLY      8'h0c
`define UPF_ALARM_DLY     8'h10
`define UPF_RST_DLY       8'h14
`define UPF_STATUS        8'h18
`define UPF_TRIP_REM      8'h1c
`define UPF_ALARM_REM     8'h20
`define UPF_RATIO_TRIP    8'h24
`define UPF_RATIO_ALARM   8'h28
`define UPF_CNT_BASE      8'h30
`define UPF_CNT_CLR       8'h44
`define UPF_REC_IDX       8'h48
`define UPF_REC_TIME      8'h4c
`define UPF_REC_DATA      8'h50
`define UPF_REC_REM       8'h54

// ----------------------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------------------
`define UPF_CTRL_MODE_LSB 0
`define UPF_CTRL_FRC_LSB  3
`define UPF_CTRL_SEL_BIT  6
`define UPF_CTRL_TONLY    7
`define UPF_CTRL_RST      8'h00
`define UPF_SET_MIN       7'h05
`define UPF_SET_MAX       7'h63
`define UPF_TRIP_SET_RST  7'h50
`define UPF_ALM_SET_RST   7'h5a
`define UPF_DLY_RST       19'h00064
`define UPF_RST_DLY_RST   19'h00000

`endif

/* File: upf_pkg.sv */
// Types shared by the power factor stage and its record memory
package upf_pkg;

  // Function mode, register codes 5..7 are illegal
  typedef enum logic [2:0] {
    upf_m_on,
    upf_m_blocked,
    upf_m_test,
    upf_m_test_blocked,
    upf_m_off
  } upf_mode_t;

  // Reported condition, also the force code
  typedef enum logic [2:0] {
    upf_c_normal,
    upf_c_start,
    upf_c_trip,
    upf_c_blocked,
    upf_c_alarm_start,
    upf_c_alarm
  } upf_cond_t;

  // Event code stored in a record
  typedef enum logic [1:0] {
    upf_e_start,
    upf_e_trip,
    upf_e_blocked
  } upf_evt_t;

endpackage

/* File: upf_rec_if.sv */
// Record write and read channel between the stage and its record memory
`timescale 1ns/1ps
interface upf_rec_if #(
  parameter int W = 78
);
  logic         wr;
  logic [W-1:0] wdata;
  logic [3:0]   idx;
  logic [W-1:0] rdata;

  modport stage (output wr, output wdata, output idx, input rdata);
  modport mem   (input wr, input wdata, input idx, output rdata);
endinterface

/* File: upf_rec_mem.sv */
// Rolling memory of the most recent time-stamped event records
`timescale 1ns/1ps
module upf_rec_mem import upf_pkg::*; #(
  parameter int DEPTH = 12,
  parameter int W     = 78
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Record channel
  upf_rec_if.mem   rec
);

  logic [W-1:0] mem_q [DEPTH];
  logic [3:0]   wp_q;
  logic [3:0]   fill_q;
  logic [3:0]   ra;

  // ----------------------------------------------------------------------------
  // Write side: oldest record is overwritten once full
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wp_q   <= 4'h0;
      fill_q <= 4'h0;
    end else if (rec.wr) begin
      wp_q <= (wp_q == 4'(DEPTH - 1)) ? 4'h0 : wp_q + 4'h1;
      if (fill_q != 4'(DEPTH)) begin
        fill_q <= fill_q + 4'h1;
      end
    end
  end

  // Storage has no reset; unused slots are masked by the fill level
  always_ff @(posedge clk) begin
    if (rec.wr) begin
      mem_q[wp_q] <= rec.wdata;
    end
  end

  // Index 0 is the newest record
  always_comb begin
    ra = (wp_q > rec.idx) ? wp_q - rec.idx - 4'h1 : 4'(DEPTH) + wp_q - rec.idx - 4'h1;
  end

  // Registered read data, zero beyond the fill level
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rec.rdata <= '0;
    end else if (rec.idx < fill_q) begin
      rec.rdata <= mem_q[ra];
    end else begin
      rec.rdata <= '0;
    end
  end

endmodule

/* File: upf_stage.sv */
// Under power factor protection stage with definite-time trip and alarm paths
//
// Operation
// [RQ1] Only input is three-phase power factor, sampled every 5 ms tick.
// [RQ2] Static select picks first or second power module, first by default.
// [RQ3] Mode On, Blocked, Test, Test/Blocked or Off, On default, when allowed.
// [RQ4] With forcing allowed, forced condition overrides report; Normal by default.
// [RQ5] Mode, force and source are static, untouched by setting group changes.
// [RQ6] Path picks up when power factor falls below its threshold.
// [RQ7] Path releases only above 103 percent of its threshold, fixed.
// [RQ8] Trip-only or trip-plus-alarm operation; alarm path off in trip-only.
// [RQ9] Trip threshold in 0.01 steps within range, default 0.80.
// [RQ10] Alarm threshold default 0.90, same range, active only with alarms.
// [RQ11] Pick-up settings take effect live while the stage runs.
// [RQ12] Condition reported as Normal, Start, Trip, Blocked, Alarm Start or Alarm.
// [RQ13] Signed time remaining to trip in 5 ms units.
// [RQ14] Non-negative time remaining to alarm in 5 ms units.
// [RQ15] Expected alarm and operate times reported in 5 ms units.
// [RQ16] Measured to threshold ratios for alarm and trip, 0.01 resolution.
// [RQ17] Block sampled per tick; blocks pick-up, or clears start and releases.
// [RQ18] Operate and reset use definite-time delays only.
// [RQ19] Clearable counters and ON/OFF events for all five conditions.
// [RQ20] Start, trip and blocked ON events stored in twelve newest records.
// [RQ21] Trip and alarm paths evaluated independently each tick.
// [RQ22] Off gives no outputs; Blocked reports Blocked and suppresses outputs.
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "upf_map.svh"
module upf_stage import upf_pkg::*; #(
  parameter int TICK_CYCLES = `UPF_TICK_CYC,
  parameter int NUM_MODULES = 2,
  parameter int DW          = 19,
  parameter int REC_DEPTH   = 12
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // Measurement, power factor in hundredths
  input  wire logic [6:0]  pf_first,
  input  wire logic [6:0]  pf_second,
  // System inputs
  input  wire logic        block_in,
  input  wire logic        mode_allow,
  input  wire logic        force_allow,
  input  wire logic [2:0]  set_group,
  input  wire logic [31:0] timestamp,
  // Stage outputs
  output logic             start_o,
  output logic             trip_o,
  output logic             alarm_start_o,
  output logic             alarm_o,
  output logic             blocked_o,
  output upf_cond_t        cond_o,
  output logic      [4:0]  evt_on,
  output logic      [4:0]  evt_off
);

  localparam int RW = 78;

  logic [31:0]          div_q;
  logic                 tick_q;
  logic                 eval_q;
  logic [7:0]           ctrl_q;
  logic [6:0]           trip_set_q;
  logic [6:0]           alarm_set_q;
  logic [DW-1:0]        trip_dly_q;
  logic [DW-1:0]        alarm_dly_q;
  logic [DW-1:0]        rst_dly_q;
  logic [6:0]           pf_q;
  logic                 blk_q;
  logic [6:0]           hist_q [`UPF_PREFAULT_TAP];
  logic [3:0]           rec_idx_q;
  upf_mode_t            mode_eff;
  upf_cond_t            cond_d;
  upf_cond_t            frc;
  logic                 run;
  logic                 mode_blk;
  logic [4:0]           flag_d;
  logic [4:0]           flag_q;
  logic [4:0]           rise;
  logic [15:0]          cnt_q [5];
  logic [6:0]           set_w [2];
  logic [DW-1:0]        dly_w [2];
  logic                 en_w [2];
  logic [1:0]           start_q;
  logic [1:0]           op_q;
  logic [1:0]           blkd_q;
  logic [1:0]           pick_q;
  logic [DW-1:0]        cnt_p_q [2];
  logic [DW-1:0]        relc_q [2];
  logic [15:0]          ratio_q [2];
  logic signed [DW:0]   rem [2];
  logic [6:0]           wset;
  logic [RW-1:0]        rec_word;
  upf_evt_t             rec_evt;

  upf_rec_if #(.W(RW)) rec ();

  // ----------------------------------------------------------------------------
  // 5 ms processing tick and measurement sampling
  // ----------------------------------------------------------------------------
  // Tick divider; evaluation runs one cycle later on the sampled value
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_q  <= 32'h0;
      tick_q <= 1'b0;
      eval_q <= 1'b0;
    end else begin
      tick_q <= (div_q == 32'(TICK_CYCLES - 1));
      div_q  <= (div_q == 32'(TICK_CYCLES - 1)) ? 32'h0 : div_q + 32'h1;
      eval_q <= tick_q;
    end
  end

  // Source and block sampled once per tick
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pf_q  <= 7'h0;
      blk_q <= 1'b0;
    end else if (tick_q) begin
      pf_q  <= (NUM_MODULES > 1 && ctrl_q[`UPF_CTRL_SEL_BIT]) ? pf_second : pf_first; // RQ1 RQ2
      blk_q <= block_in; // RQ17
    end
  end

  // Sample history for pre-trigger and pre-fault values
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `UPF_PREFAULT_TAP; i++) begin
        hist_q[i] <= 7'h0;
      end
    end else if (tick_q) begin
      hist_q[0] <= pf_q;
      for (int i = 1; i < `UPF_PREFAULT_TAP; i++) begin
        hist_q[i] <= hist_q[i-1];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Settings
  // ----------------------------------------------------------------------------
  // Thresholds are clamped to the legal range so the ratio never divides by zero
  always_comb begin
    wset = wdata[6:0];
    if (wset < `UPF_SET_MIN) begin
      wset = `UPF_SET_MIN;
    end else if (wset > `UPF_SET_MAX) begin
      wset = `UPF_SET_MAX;
    end
  end

  // Control word is a single static register, not part of any setting group
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q      <= `UPF_CTRL_RST;
      trip_set_q  <= `UPF_TRIP_SET_RST; // RQ9
      alarm_set_q <= `UPF_ALM_SET_RST; // RQ10
      trip_dly_q  <= `UPF_DLY_RST;
      alarm_dly_q <= `UPF_DLY_RST;
      rst_dly_q   <= `UPF_RST_DLY_RST;
      rec_idx_q   <= 4'h0;
    end else if (wr) begin
      unique case (addr)
        `UPF_CTRL:      ctrl_q      <= wdata[7:0]; // RQ5
        `UPF_TRIP_SET:  trip_set_q  <= wset; // RQ9 RQ11
        `UPF_ALARM_SET: alarm_set_q <= wset; // RQ10 RQ11
        `UPF_TRIP_DLY:  trip_dly_q  <= wdata[DW-1:0]; // RQ18
        `UPF_ALARM_DLY: alarm_dly_q <= wdata[DW-1:0];
        `UPF_RST_DLY:   rst_dly_q   <= wdata[DW-1:0];
        `UPF_REC_IDX:   rec_idx_q   <= (wdata[3:0] < 4'(REC_DEPTH)) ? wdata[3:0] : 4'h0;
        default: ;
      endcase
    end
  end

  // Effective mode; illegal codes fall back to On
  always_comb begin
    mode_eff = upf_m_on;
    if (mode_allow) begin
      unique case (ctrl_q[`UPF_CTRL_MODE_LSB +: 3])
        3'h1:    mode_eff = upf_m_blocked;
        3'h2:    mode_eff = upf_m_test;
        3'h3:    mode_eff = upf_m_test_blocked;
        3'h4:    mode_eff = upf_m_off;
        default: mode_eff = upf_m_on;
      endcase
    end
    run      = (mode_eff == upf_m_on) || (mode_eff == upf_m_test); // RQ3
    mode_blk = (mode_eff == upf_m_blocked) || (mode_eff == upf_m_test_blocked);
  end

  // ----------------------------------------------------------------------------
  // Trip (0) and alarm (1) definite-time paths
  // ----------------------------------------------------------------------------
  assign set_w[0] = trip_set_q;
  assign set_w[1] = alarm_set_q;
  assign dly_w[0] = trip_dly_q;
  assign dly_w[1] = alarm_dly_q;
  assign en_w[0]  = 1'b1;
  assign en_w[1]  = !ctrl_q[`UPF_CTRL_TONLY]; // RQ8

  for (genvar p = 0; p < 2; p++) begin : g_path
    logic pu;
    logic rel;
    logic pick_n;

    assign pu     = pf_q < set_w[p]; // RQ6
    assign rel    = (14'(pf_q) * 14'(`UPF_PCT)) > (14'(set_w[p]) * 14'(`UPF_RESET_PCT)); // RQ7
    assign pick_n = pu || (pick_q[p] && !rel);
    assign rem[p] = $signed({1'b0, dly_w[p]}) - $signed({1'b0, cnt_p_q[p]}); // RQ13

    // Pick-up, block handling and delay timing, once per tick
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        pick_q[p]  <= 1'b0;
        start_q[p] <= 1'b0;
        op_q[p]    <= 1'b0;
        blkd_q[p]  <= 1'b0;
        cnt_p_q[p] <= '0;
        relc_q[p]  <= '0;
      end else if (eval_q) begin // RQ21
        if (!run || !en_w[p]) begin
          pick_q[p]  <= 1'b0;
          start_q[p] <= 1'b0;
          op_q[p]    <= 1'b0;
          blkd_q[p]  <= 1'b0;
          cnt_p_q[p] <= '0;
          relc_q[p]  <= '0;
        end else begin
          pick_q[p] <= pick_n;
          blkd_q[p] <= pick_n && blk_q; // RQ17
          if (pick_n && !blk_q) begin
            start_q[p] <= 1'b1;
            relc_q[p]  <= '0;
            op_q[p]    <= (cnt_p_q[p] + 1'b1 >= dly_w[p]); // RQ18
            if (cnt_p_q[p] < dly_w[p]) begin
              cnt_p_q[p] <= cnt_p_q[p] + 1'b1;
            end
          end else begin
            // Release timing: elapsed time is held until the reset delay runs out
            start_q[p] <= 1'b0; // RQ17
            op_q[p]    <= 1'b0;
            if (relc_q[p] >= rst_dly_q) begin
              cnt_p_q[p] <= '0; // RQ18
            end else begin
              relc_q[p] <= relc_q[p] + 1'b1;
            end
          end
        end
      end
    end

    // Measured to threshold ratio in hundredths
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        ratio_q[p] <= 16'h0;
      end else if (eval_q) begin
        ratio_q[p] <= 16'((16'(pf_q) * 16'(`UPF_PCT)) / 16'(set_w[p])); // RQ16
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Condition, forcing and outputs
  // ----------------------------------------------------------------------------
  // Flag order: 0 alarm start, 1 alarm, 2 start, 3 trip, 4 blocked
  always_comb begin
    frc    = upf_c_normal;
    cond_d = upf_c_normal;
    flag_d = 5'h00;
    unique case (ctrl_q[`UPF_CTRL_FRC_LSB +: 3])
      3'h1:    frc = upf_c_start;
      3'h2:    frc = upf_c_trip;
      3'h3:    frc = upf_c_blocked;
      3'h4:    frc = upf_c_alarm_start;
      3'h5:    frc = upf_c_alarm;
      default: frc = upf_c_normal;
    endcase
    if (force_allow) begin
      cond_d = frc; // RQ4
    end else if (mode_blk) begin
      cond_d = upf_c_blocked; // RQ22
    end else if (run) begin
      if (op_q[0]) begin
        cond_d = upf_c_trip; // RQ12
      end else if (start_q[0]) begin
        cond_d = upf_c_start;
      end else if (op_q[1]) begin
        cond_d = upf_c_alarm;
      end else if (start_q[1]) begin
        cond_d = upf_c_alarm_start;
      end else if (|blkd_q) begin
        cond_d = upf_c_blocked;
      end
    end
    if (force_allow || mode_blk) begin
      flag_d[0] = (cond_d == upf_c_alarm_start);
      flag_d[1] = (cond_d == upf_c_alarm);
      flag_d[2] = (cond_d == upf_c_start);
      flag_d[3] = (cond_d == upf_c_trip);
      flag_d[4] = (cond_d == upf_c_blocked);
    end else if (run) begin
      flag_d = {|blkd_q, op_q[0], start_q[0], op_q[1], start_q[1]}; // RQ22
    end
  end

  assign rise = flag_d & ~flag_q;

  // Flags, condition and one-cycle events
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flag_q  <= 5'h00;
      cond_o  <= upf_c_normal;
      evt_on  <= 5'h00;
      evt_off <= 5'h00;
    end else begin
      flag_q  <= flag_d;
      cond_o  <= cond_d; // RQ12
      evt_on  <= rise; // RQ19
      evt_off <= ~flag_d & flag_q;
    end
  end

  assign alarm_start_o = flag_q[0];
  assign alarm_o       = flag_q[1];
  assign start_o       = flag_q[2];
  assign trip_o        = flag_q[3];
  assign blocked_o     = flag_q[4];

  // Occurrence counters; a clear in the same cycle as a new event leaves a count of one
  for (genvar c = 0; c < 5; c++) begin : g_cnt
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        cnt_q[c] <= 16'h0;
      end else if (wr && addr == `UPF_CNT_CLR && wdata[c]) begin
        cnt_q[c] <= {15'h0, rise[c]}; // RQ19
      end else if (rise[c]) begin
        cnt_q[c] <= cnt_q[c] + 16'h1; // RQ19
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Event records
  // ----------------------------------------------------------------------------
  always_comb begin
    rec_evt = rise[3] ? upf_e_trip : (rise[2] ? upf_e_start : upf_e_blocked);
    rec_word = {timestamp, set_group, rec_evt, hist_q[`UPF_PRETRIG_TAP-1], pf_q,
                hist_q[`UPF_PREFAULT_TAP-1], 20'(rem[0])};
  end

  assign rec.wr    = |rise[4:2]; // RQ20
  assign rec.wdata = rec_word;
  assign rec.idx   = rec_idx_q;

  upf_rec_mem #(.DEPTH(REC_DEPTH), .W(RW)) u_rec (
    .clk    (clk),
    .resetn (resetn),
    .rec    (rec)
  );

  // ----------------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------------
  // Data stand in the cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 32'h0;
    end else if (rd) begin
      unique case (addr)
        `UPF_CTRL:        rdata <= {24'h0, ctrl_q};
        `UPF_TRIP_SET:    rdata <= {25'h0, trip_set_q};
        `UPF_ALARM_SET:   rdata <= {25'h0, alarm_set_q};
        `UPF_TRIP_DLY:    rdata <= 32'(trip_dly_q); // RQ15
        `UPF_ALARM_DLY:   rdata <= 32'(alarm_dly_q); // RQ15
        `UPF_RST_DLY:     rdata <= 32'(rst_dly_q);
        `UPF_STATUS:      rdata <= {21'h0, mode_eff, flag_q, cond_o};
        `UPF_TRIP_REM:    rdata <= 32'(rem[0]); // RQ13
        `UPF_ALARM_REM:   rdata <= rem[1][DW] ? 32'h0 : 32'(rem[1]); // RQ14
        `UPF_RATIO_TRIP:  rdata <= {16'h0, ratio_q[0]}; // RQ16
        `UPF_RATIO_ALARM: rdata <= {16'h0, ratio_q[1]}; // RQ16
        8'h30:            rdata <= {16'h0, cnt_q[0]};
        8'h34:            rdata <= {16'h0, cnt_q[1]};
        8'h38:            rdata <= {16'h0, cnt_q[2]};
        8'h3c:            rdata <= {16'h0, cnt_q[3]};
        8'h40:            rdata <= {16'h0, cnt_q[4]};
        `UPF_REC_IDX:     rdata <= {28'h0, rec_idx_q};
        `UPF_REC_TIME:    rdata <= rec.rdata[77:46];
        `UPF_REC_DATA:    rdata <= {6'h0, rec.rdata[45:20]};
        `UPF_REC_REM:     rdata <= 32'(signed'(rec.rdata[19:0]));
        default:          rdata <= 32'h0;
      endcase
    end else begin
      rdata <= 32'h0;
    end
  end

endmodule

/* File: pfp_checker_sva.sv */
// Port checker for the power factor stage
`timescale 1ns/1ps
`include "upf_map.svh"
module pfp_checker import upf_pkg::*; (
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // Register port
  input wire logic [7:0]  addr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  // Stage outputs
  input wire logic        force_allow,
  input wire logic        start_o,
  input wire logic        trip_o,
  input wire logic        alarm_start_o,
  input wire logic        alarm_o,
  input wire logic        blocked_o,
  input wire upf_cond_t   cond_o,
  input wire logic [4:0]  evt_on,
  input wire logic [4:0]  evt_off
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------------
  // Flags in event bit order
  logic [4:0] flags;
  assign flags = {blocked_o, trip_o, start_o, alarm_o, alarm_start_o};

  status_read_a: assert property ((rd && addr == `UPF_STATUS) |=> rdata[2:0] == $past(cond_o))
    else $error("status read differs from condition");
  on_event_a: assert property (evt_on == (flags & ~$past(flags)))
    else $error("on event without flag rise");
  off_event_a: assert property (evt_off == (~flags & $past(flags)))
    else $error("off event without flag fall");
  pulse_once_a: assert property (evt_on[3] |=> !evt_on[3])
    else $error("trip event longer than one cycle");
  trip_cond_a: assert property (trip_o |-> cond_o == upf_c_trip)
    else $error("trip flag without trip condition");
  start_cond_a: assert property (start_o && !trip_o |-> cond_o == upf_c_start)
    else $error("start flag without start condition");
  alarm_cond_a: assert property (alarm_o && !trip_o && !start_o |-> cond_o == upf_c_alarm)
    else $error("alarm flag without alarm condition");
  normal_quiet_a: assert property (cond_o == upf_c_normal |-> flags == 5'h00)
    else $error("flag raised in normal condition");
  block_start_a: assert property (!force_allow && blocked_o |-> !start_o)
    else $error("start flag while blocked");
  // Main scenarios seen
  trip_c: cover property ($rose(trip_o));
  alarm_c: cover property ($rose(alarm_o));
  block_c: cover property ($rose(blocked_o));
endmodule

bind upf_stage pfp_checker i_chk (.clk, .resetn, .addr, .rd, .rdata, .force_allow, .start_o,
  .trip_o, .alarm_start_o, .alarm_o, .blocked_o, .cond_o, .evt_on, .evt_off);

/* File: power_factor_protection_test.sv */
// Self-checking bench for the power factor stage
`timescale 1ns/1ps
`include "upf_map.svh"
module power_factor_protection_test import upf_pkg::*;;
  // Short tick keeps the run brief
  localparam int TICK = 10;
  logic        clk, resetn, wr, rd, block_in, mode_allow, force_allow;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, rd_val;
  logic [6:0]  pf_first, pf_second;
  logic        start_o, trip_o, alarm_start_o, alarm_o, blocked_o;
  logic [4:0]  evt_on, evt_off;
  upf_cond_t   cond_o;
  int          fails, checks_done;

  upf_stage #(.TICK_CYCLES(TICK)) i_dut (.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata,
    .pf_first, .pf_second, .block_in, .mode_allow, .force_allow, .set_group(3'h2),
    .timestamp(32'h0000_1234), .start_o, .trip_o, .alarm_start_o, .alarm_o, .blocked_o,
    .cond_o, .evt_on, .evt_off);

  // Free running clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data is only valid in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Five ticks cover pick-up, a two tick delay and the output latency
  task automatic settle(input logic [7:0] c, input logic [6:0] p1, p2, input logic b);
    wr_reg(`UPF_CTRL, {24'h0, c});
    @(posedge clk);
    pf_first <= p1;
    pf_second <= p2;
    block_in <= b;
    repeat (5 * TICK) @(posedge clk);
    #1;
  endtask
  task automatic idle;
    settle(8'h00, 7'h64, 7'h64, 1'b0);
  endtask
  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_regs;
    logic [7:0]  a [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'hfc};
    logic [31:0] e [7] = '{32'h0, 32'h50, 32'h5a, 32'h64, 32'h64, 32'h0, 32'h0};
    for (int i = 0; i < 7; i++) begin
      rd_reg(a[i], rd_val);
      check(rd_val, e[i]);
    end
    wr_reg(`UPF_TRIP_SET, 32'h1);
    rd_reg(`UPF_TRIP_SET, rd_val);
    check(rd_val, 32'h5);
    wr_reg(`UPF_TRIP_SET, 32'h50);
    wr_reg(`UPF_ALARM_DLY, 32'h2);
    $display("t_regs done");
  endtask
  task automatic t_trip;
    settle(8'h00, 7'h4f, 7'h64, 1'b0);
    check({start_o, trip_o, alarm_o}, 3'h5);
    rd_reg(`UPF_STATUS, rd_val);
    check(rd_val[2:0], upf_c_start);
    // Shorter delay written while the stage is timing
    wr_reg(`UPF_TRIP_DLY, 32'h2);
    repeat (3 * TICK) @(posedge clk);
    #1;
    check(trip_o, 1'b1);
    settle(8'h00, 7'h52, 7'h64, 1'b0);
    check(trip_o, 1'b1);
    settle(8'h00, 7'h53, 7'h64, 1'b0);
    check({trip_o, alarm_o}, 2'h1);
    settle(8'h00, 7'h5d, 7'h64, 1'b0);
    check(cond_o, upf_c_normal);
    $display("t_trip done");
  endtask
  task automatic t_ratio_block;
    settle(8'h00, 7'h28, 7'h64, 1'b0);
    rd_reg(`UPF_RATIO_TRIP, rd_val);
    check(rd_val, 32'h32);
    idle;
    settle(8'h00, 7'h4f, 7'h64, 1'b1);
    check({blocked_o, start_o, trip_o}, 3'h4);
    settle(8'h00, 7'h4f, 7'h64, 1'b0);
    check(trip_o, 1'b1);
    idle;
    $display("t_ratio_block done");
  endtask
  task automatic t_modes;
    for (int m = 0; m < 5; m++) begin
      settle(m[7:0], 7'h4f, 7'h64, 1'b0);
      check(trip_o, (m == 0 || m == 2));
      idle;
    end
    @(posedge clk) mode_allow <= 1'b0;
    settle(8'h04, 7'h4f, 7'h64, 1'b0);
    check(trip_o, 1'b1);
    idle;
    @(posedge clk) mode_allow <= 1'b1;
    $display("t_modes done");
  endtask
  task automatic t_force;
    @(posedge clk) force_allow <= 1'b1;
    for (int f = 0; f < 6; f++) begin
      wr_reg(`UPF_CTRL, {26'h0, f[2:0], 3'h0});
      repeat (2 * TICK) @(posedge clk);
      #1;
      check(cond_o, f[2:0]);
    end
    @(posedge clk) force_allow <= 1'b0;
    idle;
    $display("t_force done");
  endtask
  task automatic t_sel_only;
    settle(8'h40, 7'h64, 7'h4f, 1'b0);
    check(trip_o, 1'b1);
    settle(8'h00, 7'h64, 7'h4f, 1'b0);
    check(trip_o, 1'b0);
    settle(8'h80, 7'h55, 7'h64, 1'b0);
    check(cond_o, upf_c_normal);
    settle(8'h00, 7'h55, 7'h64, 1'b0);
    check(alarm_o, 1'b1);
    idle;
    // Eight trip rises so far, forced one included
    rd_reg(8'h3c, rd_val);
    check(rd_val, 32'h8);
    wr_reg(`UPF_CNT_CLR, 32'h8);
    rd_reg(8'h3c, rd_val);
    check(rd_val, 32'h0);
    $display("t_sel_only done");
  endtask

  // Main sequence
  initial begin
    resetn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    pf_first = 7'h64;
    pf_second = 7'h64;
    block_in = 1'b0;
    mode_allow = 1'b1;
    force_allow = 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    t_regs;
    t_trip;
    t_ratio_block;
    t_modes;
    t_force;
    t_sel_only;
    close_out;
  end
  // Watchdog well beyond the expected run of under two thousand cycles
  initial begin
    #1000000;
    fails++;
    close_out;
  end
endmodule
